/* tb/control_port_select_and_i2c_addressing_test.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// control port testbench
// ****************************************
module control_port_select_and_i2c_addressing_test;
    import cpsi_pkg::*;

    typedef struct packed {
        logic sel1;
        logic sel0;
        cpsi_addr_t addr;
        logic rw;
        cpsi_byte_t data;
        logic expAck;
    } cpsi_row_t;

    logic core_clk, rst, protocolSelPin, addr_sel_bit0_pin, addr_sel_bit1_pin;
    logic sdaOut, sdaOe, sclOut, sclOe, spiMode, i2cBusy, addrHit, rwDir, wrValid;
    logic mstScl, mstLow, sclLine, sdaLine, lastRw, highSeen, foreign, foreignDrv, spiExp;
    cpsi_byte_t rdData, wrData, lastWr;
    int errors, n_compared, hitCnt, wrCnt;
    cpsi_row_t rows [12] = '{
        '{1'h0, 1'h0, 7'h18, 1'h0, 8'hA5, 1'h1}, '{1'h0, 1'h0, 7'h19, 1'h0, 8'h3C, 1'h0},
        '{1'h0, 1'h0, 7'h1C, 1'h1, 8'h5A, 1'h0}, '{1'h0, 1'h1, 7'h19, 1'h0, 8'h96, 1'h1},
        '{1'h0, 1'h1, 7'h18, 1'h1, 8'h0F, 1'h0}, '{1'h0, 1'h1, 7'h19, 1'h1, 8'hC3, 1'h1},
        '{1'h1, 1'h0, 7'h1A, 1'h0, 8'h81, 1'h1}, '{1'h1, 1'h0, 7'h1A, 1'h1, 8'h7E, 1'h1},
        '{1'h1, 1'h0, 7'h1B, 1'h0, 8'h11, 1'h0}, '{1'h1, 1'h1, 7'h1B, 1'h0, 8'hFF, 1'h1},
        '{1'h1, 1'h1, 7'h1B, 1'h1, 8'h00, 1'h1}, '{1'h1, 1'h1, 7'h3B, 1'h0, 8'h22, 1'h0}};

    // open-drain lines with pull-ups
    assign sdaLine = ~(mstLow | (sdaOe & ~sdaOut));
    assign sclLine = mstScl & ~(sclOe & ~sclOut);

    cpsi_ctrl_port cpsi_ctrl_port_inst (.core_clk(core_clk), .rst(rst), .sclClk(sclLine), .sclPin(sclLine),
        .sdaPin(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe),
        .protocolSelPin(protocolSelPin), .addr_sel_bit0_pin(addr_sel_bit0_pin),
        .addr_sel_bit1_pin(addr_sel_bit1_pin), .rdData(rdData), .spiMode(spiMode), .i2cBusy(i2cBusy),
        .addrHit(addrHit), .rwDir(rwDir), .wrValid(wrValid), .wrData(wrData));

    cpsi_bus_master #(.HALF(15)) cpsi_bus_master_inst (.sdaLine(sdaLine), .sclDrv(mstScl), .sdaLowDrv(mstLow));

    // core clock, 100 ns
    initial
    begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end

    // catch core-side pulses and any drive of a line high
    always @(negedge core_clk)
    begin
        if (addrHit === 1'h1)
        begin
            hitCnt++;
            lastRw = rwDir;
        end
        if (wrValid === 1'h1)
        begin
            wrCnt++;
            lastWr = wrData;
        end
        if ((sdaOe === 1'h1 && sdaOut !== 1'h0) || sclOe !== 1'h0)
            highSeen = 1'h1;
        if (foreign && sdaOe !== 1'h0)
            foreignDrv = 1'h1;
    end

    task automatic check1(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask : check1

    task automatic check8(input string name, input cpsi_byte_t exp, input cpsi_byte_t got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check8

    task automatic conclude();
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // reset pulse of four core cycles, then strap settle time
    task automatic pulse_reset(input logic sel);
        @(posedge core_clk);
        #1 rst = 1'h1;
        protocolSelPin = sel;
        repeat (2) @(posedge core_clk);
        check1("sdaOeRst", 1'h0, sdaOe);
        check1("addrHitRst", 1'h0, addrHit);
        check1("spiModeRst", 1'h0, spiMode);
        repeat (2) @(posedge core_clk);
        #1 rst = 1'h0;
        repeat (8) @(posedge core_clk);
        check1("spiMode", sel, spiMode);
        spiExp = sel;
    endtask : pulse_reset

    // one whole frame: address, one data byte, stop
    task automatic run_row(input cpsi_row_t r);
        logic ackA, ackD;
        cpsi_byte_t got;
        int hit0, wr0;
        @(posedge core_clk);
        #1 addr_sel_bit1_pin = r.sel1;
        addr_sel_bit0_pin = r.sel0;
        rdData = r.data;
        repeat (4) @(posedge core_clk);
        hit0 = hitCnt;
        wr0 = wrCnt;
        foreign = ~r.expAck;
        cpsi_bus_master_inst.start_frame();
        cpsi_bus_master_inst.byte_out({r.addr, r.rw}, ackA);
        check1("addrAck", r.expAck, ackA);
        check1("i2cBusy", ~spiExp, i2cBusy);
        if (r.rw)
        begin
            cpsi_bus_master_inst.byte_in(got, 1'h0);
            check8("readByte", r.expAck ? r.data : 8'hFF, got);
        end
        else
        begin
            cpsi_bus_master_inst.byte_out(r.data, ackD);
            check1("dataAck", r.expAck, ackD);
        end
        cpsi_bus_master_inst.stop_frame();
        foreign = 1'h0;
        repeat (6) @(posedge core_clk);
        check1("i2cBusyEnd", 1'h0, i2cBusy);
        check1("addrHit", r.expAck, 1'(hitCnt - hit0 == 1));
        check1("wrValid", r.expAck & ~r.rw, 1'(wrCnt - wr0 == 1));
        if (r.expAck)
            check1("rwDir", r.rw, lastRw);
        if (r.expAck && !r.rw)
            check8("wrData", r.data, lastWr);
    endtask : run_row

    // watchdog
    initial
    begin
        repeat (40000) @(posedge core_clk);
        errors++;
        conclude();
    end

    // main sequence
    initial
    begin
        rst = 1'h1;
        protocolSelPin = 1'h0;
        addr_sel_bit0_pin = 1'h0;
        addr_sel_bit1_pin = 1'h0;
        rdData = 8'h00;
        errors = 0;
        n_compared = 0;
        hitCnt = 0;
        wrCnt = 0;
        lastRw = 1'h0;
        lastWr = 8'h00;
        highSeen = 1'h0;
        foreign = 1'h0;
        foreignDrv = 1'h0;
        spiExp = 1'h0;
        repeat (4) @(posedge core_clk);
        #1 rst = 1'h0;
        repeat (8) @(posedge core_clk);
        check1("spiModeInit", 1'h0, spiMode);
        foreach (rows[i])
            run_row(rows[i]);
        // strap only changes under reset
        pulse_reset(1'h1);
        run_row('{1'h0, 1'h0, 7'h18, 1'h0, 8'h42, 1'h0});
        pulse_reset(1'h0);
        run_row('{1'h0, 1'h0, 7'h18, 1'h1, 8'h99, 1'h1});
        check1("driveHigh", 1'h0, highSeen);
        check1("foreignDrive", 1'h0, foreignDrv);
        conclude();
    end
endmodule : control_port_select_and_i2c_addressing_test

`default_nettype wire

/* tb/cpsi_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// two-wire bus master model
// ****************************************
module cpsi_bus_master #(
    parameter int HALF = 15
) (
    input wire logic sdaLine,
    output logic sclDrv,
    output logic sdaLowDrv
);
    logic tick;

    // link base clock, phase unrelated to the core clock
    initial
    begin
        tick = 1'h0;
        sclDrv = 1'h1;
        sdaLowDrv = 1'h0;
        #17;
        forever #40 tick = ~tick;
    end

    // one low or high phase of the bus clock
    task automatic wait_half();
        repeat (HALF) @(posedge tick);
    endtask : wait_half

    // start or repeated start: data falls while clock high
    task automatic start_frame();
        sdaLowDrv = 1'h0;
        wait_half();
        sclDrv = 1'h1;
        wait_half();
        sdaLowDrv = 1'h1;
        wait_half();
        sclDrv = 1'h0;
    endtask : start_frame

    // one bit: data set while clock low, line sampled at end of high
    task automatic put_bit(input logic b, output logic s);
        sdaLowDrv = ~b;
        wait_half();
        sclDrv = 1'h1;
        wait_half();
        s = sdaLine;
        sclDrv = 1'h0;
    endtask : put_bit

    // byte out msb first, then release for the ack slot
    task automatic byte_out(input logic [7:0] b, output logic ackSeen);
        logic s;
        for (int i = 7; i >= 0; i--)
            put_bit(b[i], s);
        put_bit(1'h1, s);
        ackSeen = ~s;
    endtask : byte_out

    // byte in msb first, then own ack or nack
    task automatic byte_in(output logic [7:0] b, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            put_bit(1'h1, s);
            b[i] = s;
        end
        put_bit(~ack, s);
    endtask : byte_in

    // stop: data rises while clock high, clock then stands high
    task automatic stop_frame();
        sdaLowDrv = 1'h1;
        wait_half();
        sclDrv = 1'h1;
        wait_half();
        sdaLowDrv = 1'h0;
        wait_half();
    endtask : stop_frame
endmodule : cpsi_bus_master

`default_nettype wire

/* verilog/cpsi_ctrl_port.sv */
`timescale 1ns/1ps
`default_nettype none

`include "cpsi_map.svh"

module cpsi_ctrl_port (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sclClk,
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sdaOut,
    output logic sdaOe,
    output logic sclOut,
    output logic sclOe,
    input wire logic protocolSelPin,
    input wire logic addr_sel_bit0_pin,
    input wire logic addr_sel_bit1_pin,
    input wire cpsi_pkg::cpsi_byte_t rdData,
    output logic spiMode,
    output logic i2cBusy,
    output logic addrHit,
    output logic rwDir,
    output logic wrValid,
    output cpsi_pkg::cpsi_byte_t wrData
);
    import cpsi_pkg::*;

    // ************************************
    // pin synchronisers
    // ************************************

    logic sclS, sdaS, selS, a1S, a0S;
    logic addrTglS, wrTglS;
    logic addrTglL, rwL, wrTglL, sdaLowL;
    cpsi_byte_t wrByteL;

    // bus levels, strap and select pins into core_clk
    cpsi_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .clk(core_clk),
        .rst(rst),
        .din({sclPin, sdaPin, protocolSelPin, addr_sel_bit1_pin, addr_sel_bit0_pin}),
        .dout({sclS, sdaS, selS, a1S, a0S})
    );

    // event toggles from the link side
    cpsi_sync #(
        .WIDTH(2)
    ) u_evt_sync (
        .clk(core_clk),
        .rst(rst),
        .din({addrTglL, wrTglL}),
        .dout({addrTglS, wrTglS})
    );

    // ************************************
    // strap capture
    // ************************************

    logic [1:0] strapCnt_r, strapCntNxt;
    logic strapDone_r, strapDoneNxt;
    logic spiMode_r, spiModeNxt;

    // catch the protocol strap once, after the synchroniser has filled
    always_comb
    begin
        strapCntNxt = strapCnt_r;
        strapDoneNxt = strapDone_r;
        spiModeNxt = spiMode_r;
        if (!strapDone_r)
        begin
            strapCntNxt = 2'(strapCnt_r + 2'h1);
            if (strapCnt_r == `CPSI_STRAP_WAIT)
            begin
                strapDoneNxt = 1'b1;
                spiModeNxt = (selS != `CPSI_SEL_TWO_WIRE);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            strapCnt_r <= 2'h0;
            strapDone_r <= 1'b0;
            spiMode_r <= 1'b0;
        end
        else
        begin
            strapCnt_r <= strapCntNxt;
            strapDone_r <= strapDoneNxt;
            spiMode_r <= spiModeNxt;
        end
    end

    // ************************************
    // frame tracking and address
    // ************************************

    logic sclD_r, sdaD_r;
    logic startDet, stopDet;
    logic inFrame_r, inFrameNxt;
    logic linkRst_r, linkRstNxt;
    cpsi_addr_t myAddr_r, myAddrNxt;
    cpsi_byte_t rdHold_r, rdHoldNxt;
    logic i2cOn;

    // start and stop seen on the synchronised levels
    assign startDet = sclS && sclD_r && sdaD_r && !sdaS;
    assign stopDet = sclS && sclD_r && !sdaD_r && sdaS;
    assign i2cOn = strapDone_r && !spiMode_r;

    // link logic is held in reset outside frames and pulsed on every start
    always_comb
    begin
        inFrameNxt = inFrame_r;
        if (startDet)
            inFrameNxt = 1'b1;
        else if (stopDet)
            inFrameNxt = 1'b0;
        linkRstNxt = !i2cOn || !inFrameNxt || startDet;
        myAddrNxt = myAddr_r;
        rdHoldNxt = rdHold_r;
        if (!inFrame_r)
        begin
            myAddrNxt = {`CPSI_ADDR_HI, a1S, a0S};
            rdHoldNxt = rdData;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sclD_r <= 1'b1;
            sdaD_r <= 1'b1;
            inFrame_r <= 1'b0;
            linkRst_r <= 1'b1;
            myAddr_r <= `CPSI_ADDR_DEFAULT;
            rdHold_r <= 8'hFF;
        end
        else
        begin
            sclD_r <= sclS;
            sdaD_r <= sdaS;
            inFrame_r <= inFrameNxt;
            linkRst_r <= linkRstNxt;
            myAddr_r <= myAddrNxt;
            rdHold_r <= rdHoldNxt;
        end
    end

    // ************************************
    // link side
    // ************************************

    // bit engine on the bus clock
    cpsi_link u_link (
        .sclClk(sclClk),
        .linkRst(linkRst_r),
        .sdaIn(sdaPin),
        .myAddr(myAddr_r),
        .rdByte(rdHold_r),
        .sdaLow_r(sdaLowL),
        .addrTgl_r(addrTglL),
        .rw_r(rwL),
        .wrTgl_r(wrTglL),
        .wrByte_r(wrByteL)
    );

    assign sdaOe = sdaLowL;

    // ************************************
    // events back in core_clk
    // ************************************

    logic addrTglD_r, wrTglD_r;
    logic addrHit_r, addrHitNxt;
    logic rwDir_r, rwDirNxt;
    logic wrValid_r, wrValidNxt;
    cpsi_byte_t wrData_r, wrDataNxt;
    logic busy_r;
    logic [2:0] rstPipe_r, rstPipeNxt;
    logic evtMask;

    // toggle edges become one-cycle pulses; words are stable by then
    always_comb
    begin
        rstPipeNxt = {rstPipe_r[1:0], linkRst_r};
        evtMask = linkRst_r || (rstPipe_r != 3'h0); // link reset zeroes its toggles; hide that edge
        addrHitNxt = (addrTglS ^ addrTglD_r) && !evtMask;
        wrValidNxt = (wrTglS ^ wrTglD_r) && !evtMask;
        rwDirNxt = addrHitNxt ? rwL : rwDir_r;
        wrDataNxt = wrValidNxt ? wrByteL : wrData_r;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            addrTglD_r <= 1'b0;
            wrTglD_r <= 1'b0;
            rstPipe_r <= 3'h7;
            addrHit_r <= 1'b0;
            rwDir_r <= 1'b0;
            wrValid_r <= 1'b0;
            wrData_r <= 8'h00;
            busy_r <= 1'b0;
            sdaOut <= 1'b0;
            sclOut <= 1'b0;
            sclOe <= 1'b0;
        end
        else
        begin
            addrTglD_r <= addrTglS;
            rstPipe_r <= rstPipeNxt;
            wrTglD_r <= wrTglS;
            addrHit_r <= addrHitNxt;
            rwDir_r <= rwDirNxt;
            wrValid_r <= wrValidNxt;
            wrData_r <= wrDataNxt;
            busy_r <= inFrame_r && i2cOn;
            sdaOut <= 1'b0;
            sclOut <= 1'b0;
            sclOe <= 1'b0; // no clock stretching
        end
    end

    // the link toggles restart at zero whenever the link is reset
    assign spiMode = spiMode_r;
    assign i2cBusy = busy_r;
    assign addrHit = addrHit_r;
    assign rwDir = rwDir_r;
    assign wrValid = wrValid_r;
    assign wrData = wrData_r;

    // ************************************
    // checks
    // ************************************

    property p_spi_holds_link;
        @(posedge core_clk) disable iff (rst)
        (strapDone_r && spiMode_r) |-> linkRst_r;
    endproperty
    a_spi_holds_link: assert property (p_spi_holds_link) else $error("link active in four-wire mode");

    property p_strap_taken;
        @(posedge core_clk) disable iff (rst)
        (!strapDone_r && strapCnt_r == `CPSI_STRAP_WAIT) |=> (strapDone_r && spiMode_r == $past(selS));
    endproperty
    a_strap_taken: assert property (p_strap_taken) else $error("strap not caught as sampled");

    property p_strap_frozen;
        @(posedge core_clk) disable iff (rst)
        strapDone_r |=> (strapDone_r && $stable(spiMode_r));
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) else $error("protocol choice changed");

    property p_addr_pins;
        @(posedge core_clk) disable iff (rst)
        !inFrame_r |=> myAddr_r[1:0] == $past({a1S, a0S});
    endproperty
    a_addr_pins: assert property (p_addr_pins) else $error("address low bits not from select pins");

    property p_addr_upper;
        @(posedge core_clk) disable iff (rst)
        myAddr_r[6:2] == `CPSI_ADDR_HI;
    endproperty
    a_addr_upper: assert property (p_addr_upper) else $error("fixed address bits wrong");

    property p_addr_default;
        @(posedge core_clk) disable iff (rst)
        (!inFrame_r && !a1S && !a0S) |=> myAddr_r == `CPSI_ADDR_DEFAULT;
    endproperty
    a_addr_default: assert property (p_addr_default) else $error("grounded pins not default address");

    property p_addr_frozen;
        @(posedge core_clk) disable iff (rst)
        (inFrame_r && inFrameNxt) |=> $stable(myAddr_r);
    endproperty
    a_addr_frozen: assert property (p_addr_frozen) else $error("address moved during frame");

    property p_never_high;
        @(posedge core_clk) disable iff (rst)
        (!sdaOut && !sclOut && !sclOe);
    endproperty
    a_never_high: assert property (p_never_high) else $error("bus line driven high");

    property p_quiet_outside;
        @(posedge core_clk) disable iff (rst)
        (linkRst_r && $past(linkRst_r)) |-> !sdaOe;
    endproperty
    a_quiet_outside: assert property (p_quiet_outside) else $error("data line pulled outside a frame");

    property p_write_needs_hit;
        @(posedge core_clk) disable iff (rst)
        wrValid_r |-> (!rwDir_r && busy_r);
    endproperty
    a_write_needs_hit: assert property (p_write_needs_hit) else $error("write byte without write address");

    property p_hit_in_frame;
        @(posedge core_clk) disable iff (rst)
        addrHit_r |-> busy_r;
    endproperty
    a_hit_in_frame: assert property (p_hit_in_frame) else $error("address hit outside a frame");

    property p_rw_follows;
        @(posedge core_clk) disable iff (rst)
        addrHitNxt |=> (addrHit_r && rwDir_r == $past(rwL));
    endproperty
    a_rw_follows: assert property (p_rw_follows) else $error("direction not reported with hit");

    c_write_hit: cover property (@(posedge core_clk) disable iff (rst) addrHit_r && !rwDir_r);
    c_read_hit: cover property (@(posedge core_clk) disable iff (rst) addrHit_r && rwDir_r);
    c_write_byte: cover property (@(posedge core_clk) disable iff (rst) wrValid_r);
    c_stop_seen: cover property (@(posedge core_clk) disable iff (rst) inFrame_r && stopDet);

endmodule : cpsi_ctrl_port

`default_nettype wire

/* verilog/cpsi_link.sv */
`timescale 1ns/1ps
`default_nettype none

`include "cpsi_map.svh"

module cpsi_link (
    input wire logic sclClk,
    input wire logic linkRst,
    input wire logic sdaIn,
    input wire cpsi_pkg::cpsi_addr_t myAddr,
    input wire cpsi_pkg::cpsi_byte_t rdByte,
    output logic sdaLow_r,
    output logic addrTgl_r,
    output logic rw_r,
    output logic wrTgl_r,
    output cpsi_pkg::cpsi_byte_t wrByte_r
);
    import cpsi_pkg::*;

    cpsi_link_state_t state_r, stateNxt;
    logic [2:0] bitCnt_r, bitCntNxt;
    cpsi_byte_t shift_r, shiftNxt, byteIn, wrByteNxt;
    logic rwNxt, addrTglNxt, wrTglNxt, sdaLowNxt;

    assign byteIn = {shift_r[6:0], sdaIn};

    // ************************************
    // receive side, rising clock edge
    // ************************************

    // phase walk and bit capture
    always_comb
    begin
        stateNxt = state_r;
        bitCntNxt = bitCnt_r;
        shiftNxt = shift_r;
        rwNxt = rw_r;
        addrTglNxt = addrTgl_r;
        wrTglNxt = wrTgl_r;
        wrByteNxt = wrByte_r;
        unique case (state_r)
            LS_ADDR:
            begin
                shiftNxt = byteIn;
                bitCntNxt = 3'(bitCnt_r + 3'h1);
                if (bitCnt_r == `CPSI_BIT_LAST)
                begin
                    if (byteIn[7:1] == myAddr)
                    begin
                        stateNxt = LS_ACK_ADDR;
                        rwNxt = byteIn[`CPSI_RW_BIT];
                        addrTglNxt = ~addrTgl_r;
                    end
                    else
                        stateNxt = LS_IDLE;
                end
            end
            LS_ACK_ADDR:
                stateNxt = rw_r ? LS_READ : LS_WRITE;
            LS_WRITE:
            begin
                shiftNxt = byteIn;
                bitCntNxt = 3'(bitCnt_r + 3'h1);
                if (bitCnt_r == `CPSI_BIT_LAST)
                begin
                    stateNxt = LS_ACK_WR;
                    wrByteNxt = byteIn;
                    wrTglNxt = ~wrTgl_r;
                end
            end
            LS_ACK_WR:
                stateNxt = LS_WRITE;
            LS_READ:
            begin
                bitCntNxt = 3'(bitCnt_r + 3'h1);
                if (bitCnt_r == `CPSI_BIT_LAST)
                    stateNxt = LS_ACK_RD;
            end
            LS_ACK_RD:
                stateNxt = sdaIn ? LS_IDLE : LS_READ; // master nack ends the read
            LS_IDLE:
                stateNxt = LS_IDLE;
        endcase
    end

    always_ff @(posedge sclClk or posedge linkRst)
    begin
        if (linkRst)
        begin
            state_r <= LS_ADDR;
            bitCnt_r <= 3'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            addrTgl_r <= 1'b0;
            wrTgl_r <= 1'b0;
            wrByte_r <= 8'h00;
        end
        else
        begin
            state_r <= stateNxt;
            bitCnt_r <= bitCntNxt;
            shift_r <= shiftNxt;
            rw_r <= rwNxt;
            addrTgl_r <= addrTglNxt;
            wrTgl_r <= wrTglNxt;
            wrByte_r <= wrByteNxt;
        end
    end

    // ************************************
    // drive side, falling clock edge
    // ************************************

    // pull low for ack or a zero data bit, else release
    always_comb
    begin
        sdaLowNxt = 1'b0;
        if (state_r == LS_ACK_ADDR || state_r == LS_ACK_WR)
            sdaLowNxt = 1'b1;
        else if (state_r == LS_READ)
            sdaLowNxt = ~rdByte[3'(`CPSI_BIT_LAST - bitCnt_r)];
    end

    always_ff @(negedge sclClk or posedge linkRst)
    begin
        if (linkRst)
            sdaLow_r <= 1'b0;
        else
            sdaLow_r <= sdaLowNxt;
    end

    // ************************************
    // checks
    // ************************************

    property p_mismatch_idle;
        @(posedge sclClk) disable iff (linkRst)
        (state_r == LS_ADDR && bitCnt_r == `CPSI_BIT_LAST && byteIn[7:1] != myAddr) |=> state_r == LS_IDLE;
    endproperty
    a_mismatch_idle: assert property (p_mismatch_idle) else $error("foreign address not ignored");

    property p_rw_capture;
        @(posedge sclClk) disable iff (linkRst)
        (state_r == LS_ADDR && bitCnt_r == `CPSI_BIT_LAST && byteIn[7:1] == myAddr)
            |=> (state_r == LS_ACK_ADDR && rw_r == $past(sdaIn));
    endproperty
    a_rw_capture: assert property (p_rw_capture) else $error("direction bit not taken from eighth bit");

endmodule : cpsi_link

`default_nettype wire

/* verilog/cpsi_map.svh */
`ifndef CPSI_MAP_SVH
`define CPSI_MAP_SVH

// fixed upper five bits of the 7-bit slave address
`define CPSI_ADDR_HI 5'h06
// address answered with both select pins grounded
`define CPSI_ADDR_DEFAULT 7'h18
// position of the direction bit in the first byte
`define CPSI_RW_BIT 0
// index of the last bit of a byte
`define CPSI_BIT_LAST 3'h7
// core cycles after reset release before the strap is caught
`define CPSI_STRAP_WAIT 2'h2
// level of the protocol strap that selects the two-wire bus
`define CPSI_SEL_TWO_WIRE 1'h0

`endif

/* verilog/cpsi_pkg.sv */
`default_nettype none

package cpsi_pkg;

    // 7-bit slave address
    typedef logic [6:0] cpsi_addr_t;

    // one bus byte
    typedef logic [7:0] cpsi_byte_t;

    // link-side transfer phases
    typedef enum logic [2:0] {
        LS_ADDR,
        LS_ACK_ADDR,
        LS_WRITE,
        LS_ACK_WR,
        LS_READ,
        LS_ACK_RD,
        LS_IDLE
    } cpsi_link_state_t;

endpackage : cpsi_pkg

`default_nettype wire

/* verilog/cpsi_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module cpsi_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    import cpsi_pkg::*;

    logic [WIDTH-1:0] stage1_r;

    // two flops; the first is read only by the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1_r <= '0;
            dout <= '0;
        end
        else
        begin
            stage1_r <= din;
            dout <= stage1_r;
        end
    end

endmodule : cpsi_sync

`default_nettype wire
